// >>> tb.sv
// Self-checking bench for the type-B timer registers, clocks and capture paths.
`timescale 1ns/1ps

module tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic        standby_sleep_i = 1'b0;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, waveform_o, waveform_override_o;
  wire         capture_event_o, overflow_event_o, capture_event_i, count_event_i;
  wire         type_a_timer_tick_i, type_a_timer_restart_i, type_a_timer_zero_restart_i;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 12;
  int          i;
  int          k;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  got;
  logic [47:0] r;
  logic [7:0]  ra [0:2] = '{8'h00, 8'h04, 8'h10};
  // Columns: control A, control B, event control, standby, register read, bits seen.
  logic [47:0] tbl [0:20] = '{
    48'h0102_0100_1807, 48'h0102_1100_1803,
    48'h0102_0000_1800, 48'h0002_0100_1800,
    48'h0146_0100_1C07, 48'h0102_0101_1800,
    48'h4102_0101_1807, 48'h2102_0100_1807,
    48'h0102_4100_1807, 48'h0100_0100_1800,
    48'h0107_1100_1800, 48'h0103_0100_1807,
    48'h0103_1100_1803, 48'h0104_0100_1803,
    48'h0104_1100_1807, 48'h0105_0100_1801,
    48'h0105_1100_1800, 48'h0101_0100_1C05,
    48'h0101_1100_1C02, 48'h0106_0100_1C07,
    48'h0106_1100_1C07};

  timer_b_control_config dut (
    .clk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .standby_sleep_i, .type_a_timer_tick_i, .type_a_timer_restart_i,
    .type_a_timer_zero_restart_i, .capture_event_i, .count_event_i, .waveform_o,
    .waveform_override_o, .capture_event_o, .overflow_event_o
  );

  timer_b_partner p (
    .clk_i, .tick_o(type_a_timer_tick_i), .restart_o(type_a_timer_restart_i),
    .zero_restart_o(type_a_timer_zero_restart_i), .capture_o(capture_event_i),
    .count_o(count_event_i)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] mask(input logic [7:0] a);
    case (a)
      8'h00: mask = 32'h7F;
      8'h04: mask = 32'h77;
      default: mask = 32'h51;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Request is held until pready is sampled high, then released on that same edge, with one idle edge after.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 16)
      errors++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Disable first so the count write is not disturbed by the old clock choice.
  task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, {24'h0, b});
    apb(1'b1, 8'h10, {24'h0, e});
    apb(1'b1, 8'h30, 32'hFFFF);
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h00, {24'h0, a});
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test;
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 3; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check(rd, 32'h0);
      repeat (4) begin
        r[31:0] = $random(seed);
        apb(1'b1, ra[i], r[31:0]);
        apb(1'b0, ra[i], 32'h0);
        check(rd, r[31:0] & mask(ra[i]));
      end
      apb(1'b1, ra[i], 32'h0);
    end
    apb(1'b1, 8'h08, 32'hFF);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    $display("register test done");
    for (i = 0; i < 21; i++) begin
      r = tbl[i];
      standby_sleep_i <= r[16];
      cfg(r[47:40], r[39:32], r[31:24]);
      got = 3'h0;
      for (k = 0; k < 3; k++) begin
        p.level(k != 1, 8);
        apb(1'b0, r[15:8], 32'h0);
        got = {got[1:0], rd[0]};
      end
      p.level(1'b0, 8);
      check({29'h0, got}, {29'h0, r[2:0]});
    end
    standby_sleep_i <= 1'b0;
    $display("event table test done");
    for (i = 0; i < 3; i++) begin
      cfg(8'h01 | (i << 1), 8'h03, 8'h01);
      p.level(1'b1, 20);
      p.level(1'b0, 20);
      p.level(1'b1, 20);
      p.level(1'b0, 4);
      apb(1'b0, 8'h30, 32'h0);
      k = 32'h28 >> i;
      check({31'h0, rd + 2 >= k && rd <= k + 2}, 32'h1);
      apb(1'b0, 8'h18, 32'h0);
      check(rd & 32'h1, 32'h0);
    end
    cfg(8'h0F, 8'h00, 8'h00);
    repeat (5) p.count_pulse;
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h5);
    cfg(8'h07, 8'h00, 8'h00);
    repeat (20) @(posedge clk_i);
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h0);
    $display("clock select test done");
    cfg(8'h11, 8'h00, 8'h00);
    repeat (30) @(posedge clk_i);
    p.restart(1'b0);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, rd >= 30}, 32'h1);
    p.restart(1'b1);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, rd <= 10}, 32'h1);
    apb(1'b1, 8'h28, 32'hFFF0);
    repeat (30) @(posedge clk_i);
    apb(1'b0, 8'h18, 32'h0);
    check(rd & 32'h3, 32'h3);
    cfg(8'h00, 8'h30, 8'h00);
    repeat (2) @(posedge clk_i);
    check({30'h0, waveform_override_o, waveform_o}, 32'h3);
    $display("restart and pin test done");
    finish_test;
  end
endmodule // tb

// >>> timer_b_capture_input.v
// Capture event path: noise filter, cascade delay and edge detection.
`timescale 1ns/1ps
`include "timer_b_defines.vh"

module timer_b_capture_input #(
  parameter SAMPLES = `TB_FILTER_SAMPLES
) (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire event_i,
  input  wire filter_en_i,
  input  wire cascade_i,
  output reg  raw_rise_o,
  output reg  rise_o,
  output reg  fall_o
);

  reg [SAMPLES-1:0] history;
  reg               filtered;
  reg               delayed;
  reg               level_q;
  reg               raw_q;
  wire              stage;
  wire              level;

  // A level is accepted only after it has held for every sample in the window.
  assign stage = filter_en_i ? filtered : event_i;
  // The extra cycle matches the carry that the lower counter sends on.
  assign level = cascade_i ? delayed : stage;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      history    <= {SAMPLES{1'b0}};
      filtered   <= 1'b0;
      delayed    <= 1'b0;
      level_q    <= 1'b0;
      raw_q      <= 1'b0;
      raw_rise_o <= 1'b0;
      rise_o     <= 1'b0;
      fall_o     <= 1'b0;
    end else begin
      history <= {history[SAMPLES-2:0], event_i};
      if (&{history, event_i}) begin
        filtered <= 1'b1;
      end else if (~|{history, event_i}) begin
        filtered <= 1'b0;
      end
      delayed    <= stage;
      level_q    <= level;
      raw_q      <= event_i;
      raw_rise_o <= event_i & ~raw_q;
      rise_o     <= level & ~level_q;
      fall_o     <= ~level & level_q;
    end
  end

endmodule // timer_b_capture_input

// >>> timer_b_control_config.v
// Type-B timer top: APB registers, counter modes, capture logic and waveform.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "timer_b_defines.vh"

module timer_b_control_config #(
  parameter COUNT_W = 16
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        standby_sleep_i,
  input  wire        type_a_timer_tick_i,
  input  wire        type_a_timer_restart_i,
  input  wire        type_a_timer_zero_restart_i,
  input  wire        capture_event_i,
  input  wire        count_event_i,
  output reg         waveform_o,
  output reg         waveform_override_o,
  output reg         capture_event_o,
  output reg         overflow_event_o
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_FIRST = 3'b010;
  localparam ST_SECND = 3'b100;

  reg  [7:0]         timer_b_control_a;
  reg  [7:0]         timer_b_control_b;
  reg  [7:0]         timer_b_event_control;
  reg  [COUNT_W-1:0] counter_value;
  reg  [COUNT_W-1:0] compare_capture_value;
  reg                capture_flag;
  reg                overflow_flag;
  reg                running;
  reg  [2:0]         pair_state;
  reg                next_running;
  reg  [COUNT_W-1:0] next_count;
  reg                do_capture;
  reg                set_capture;
  reg  [2:0]         next_pair_state;
  reg                wave_level;
  reg  [31:0]        read_word;
  reg                read_hit;

  wire               enabled;
  wire               active;
  wire [2:0]         clock_source_select;
  wire [2:0]         counter_mode_select;
  wire               edge_bit;
  wire               restart_with_type_a;
  wire               restart_pulse;
  wire               tick;
  wire               raw_rise;
  wire               ev_rise;
  wire               ev_fall;
  wire               start_edge;
  wire               other_edge;
  wire               raw_start;
  wire               access;
  wire               wr_en;
  wire               rd_en;
  wire [5:0]         index;
  wire               top_hit;
  wire               byte_top_hit;
  wire               byte_duty_hit;
  wire               capture_mode;

  function is_reg;
    input [5:0] idx;
    input [5:0] want;
    begin
      is_reg = (idx == want);
    end
  endfunction

  assign clock_source_select = timer_b_control_a[`TB_A_CLOCK_SOURCE_SELECT_HI:`TB_A_CLOCK_SOURCE_SELECT_LO];
  assign counter_mode_select = timer_b_control_b[`TB_B_MODE_HI:`TB_B_MODE_LO];
  assign edge_bit            = timer_b_event_control[`TB_EV_EDGE];
  assign restart_with_type_a = timer_b_control_a[`TB_A_RESTART_A];
  assign enabled             = timer_b_control_a[`TB_A_ENABLE];
  // Standby halts the timer unless software asked it to keep running.
  assign active = enabled & (~standby_sleep_i | timer_b_control_a[`TB_A_STANDBY]);
  assign restart_pulse = restart_with_type_a & ((clock_source_select == `TB_CLK_TYPE_A) ?
                         type_a_timer_restart_i : type_a_timer_zero_restart_i);

  // The start/capture edge is positive for edge bit 0 and negative for edge bit 1.
  assign start_edge = active & timer_b_event_control[`TB_EV_INPUT_EN] &
                      (edge_bit ? ev_fall : ev_rise);
  assign other_edge = active & timer_b_event_control[`TB_EV_INPUT_EN] &
                      (edge_bit ? ev_rise : ev_fall);
  assign raw_start  = active & timer_b_event_control[`TB_EV_INPUT_EN] & raw_rise;

  assign top_hit       = (counter_value == compare_capture_value);
  assign byte_top_hit  = (counter_value[7:0] == compare_capture_value[7:0]);
  assign byte_duty_hit = (counter_value[7:0] == compare_capture_value[15:8]);
  assign capture_mode  = (counter_mode_select >= `TB_MODE_SNAPSHOT) &&
                         (counter_mode_select <= `TB_MODE_FREQ_WIDTH);

  assign access = psel_i & penable_i & pready_o;
  assign wr_en  = access & pwrite_i & (paddr_i[1:0] == 2'b00);
  assign rd_en  = access & ~pwrite_i;
  assign index  = paddr_i[7:2];

  timer_b_count_tick u_tick (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .clock_source_select_i (clock_source_select),
    .type_a_timer_tick_i   (type_a_timer_tick_i),
    .count_event_i         (count_event_i),
    .restart_i             (restart_pulse),
    .tick_o                (tick)
  );

  // The cascade delay only shifts timing; the 32-bit chain itself is the event routing.
  timer_b_capture_input u_capture (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .event_i     (capture_event_i),
    .filter_en_i (timer_b_event_control[`TB_EV_FILTER]),
    .cascade_i   (timer_b_control_a[`TB_A_CASCADE]),
    .raw_rise_o  (raw_rise),
    .rise_o      (ev_rise),
    .fall_o      (ev_fall)
  );

  always @* begin
    next_running    = running;
    next_count      = counter_value;
    next_pair_state = pair_state;
    do_capture      = 1'b0;
    set_capture     = 1'b0;
    if (tick & running & active) begin
      next_count = counter_value + 1'b1;
    end
    case (counter_mode_select)
      `TB_MODE_PERIODIC: begin
        next_running = 1'b1;
        // A disabled or halted timer must not keep matching its top and flagging.
        if (tick & running & active & top_hit) begin
          next_count  = `TB_COUNT_ZERO;
          set_capture = 1'b1;
        end
      end
      `TB_MODE_TIMEOUT: begin
        if (start_edge) begin
          next_running = 1'b1;
        end else if (other_edge) begin
          next_running = 1'b0;
        end
        if (tick & running & active & top_hit) begin
          next_count  = `TB_COUNT_ZERO;
          set_capture = 1'b1;
        end
      end
      `TB_MODE_SNAPSHOT: begin
        next_running = 1'b1;
        if (start_edge) begin
          do_capture  = 1'b1;
          set_capture = 1'b1;
        end
      end
      `TB_MODE_FREQ: begin
        next_running = 1'b1;
        if (start_edge) begin
          do_capture  = 1'b1;
          set_capture = 1'b1;
          next_count  = `TB_COUNT_ZERO;
        end
      end
      `TB_MODE_WIDTH: begin
        next_running = 1'b1;
        if (start_edge) begin
          next_count = `TB_COUNT_ZERO;
        end else if (other_edge) begin
          do_capture  = 1'b1;
          set_capture = 1'b1;
        end
      end
      `TB_MODE_FREQ_WIDTH: begin
        case (pair_state)
          ST_IDLE: begin
            next_running = 1'b0;
            if (start_edge) begin
              next_count      = `TB_COUNT_ZERO;
              next_running    = 1'b1;
              next_pair_state = ST_FIRST;
            end
          end
          ST_FIRST: begin
            if (other_edge) begin
              do_capture      = 1'b1;
              next_pair_state = ST_SECND;
            end
          end
          ST_SECND: begin
            if (start_edge) begin
              next_running    = 1'b0;
              set_capture     = 1'b1;
              next_pair_state = ST_IDLE;
            end
          end
          default: begin
            next_pair_state = ST_IDLE;
          end
        endcase
      end
      `TB_MODE_SINGLE: begin
        // Either edge starts the shot when the edge bit is set.
        if (start_edge | (edge_bit & other_edge)) begin
          next_running = 1'b1;
        end
        if (tick & running & active & top_hit) begin
          next_running = 1'b0;
          next_count   = `TB_COUNT_ZERO;
          set_capture  = 1'b1;
        end
      end
      `TB_MODE_BYTE_PULSE: begin
        next_running = 1'b1;
        if (tick & running & active & byte_top_hit) begin
          next_count = `TB_COUNT_ZERO;
        end
        if (tick & running & active & byte_duty_hit) begin
          set_capture = 1'b1;
        end
      end
      default: begin
        next_running = 1'b0;
      end
    endcase
    if (!enabled) begin
      next_running    = 1'b0;
      next_pair_state = ST_IDLE;
    end else if (restart_pulse) begin
      next_count = `TB_COUNT_ZERO;
    end
  end

  always @* begin
    case (counter_mode_select)
      `TB_MODE_SINGLE: begin
        // Async mode raises the pin on the raw edge, before filter and delay.
        wave_level = running | (timer_b_control_b[`TB_B_ASYNC] & raw_start);
      end
      `TB_MODE_BYTE_PULSE: begin
        wave_level = (counter_value[7:0] < compare_capture_value[15:8]);
      end
      default: begin
        wave_level = timer_b_control_b[`TB_B_INIT_LEVEL];
      end
    endcase
  end

  always @* begin
    read_hit  = 1'b1;
    read_word = 32'h0000_0000;
    if (is_reg(index, `TB_IDX_CTRL_A)) begin
      read_word[7:0] = timer_b_control_a;
    end else if (is_reg(index, `TB_IDX_CTRL_B)) begin
      read_word[7:0] = timer_b_control_b;
    end else if (is_reg(index, `TB_IDX_TIMER_B_EVENT_CONTROL)) begin
      read_word[7:0] = timer_b_event_control;
    end else if (is_reg(index, `TB_IDX_FLAGS)) begin
      read_word[`TB_FLAG_CAPTURE]  = capture_flag;
      read_word[`TB_FLAG_OVERFLOW] = overflow_flag;
    end else if (is_reg(index, `TB_IDX_STATUS)) begin
      read_word[`TB_STATUS_RUN] = running;
    end else if (is_reg(index, `TB_IDX_COUNT)) begin
      read_word[COUNT_W-1:0] = counter_value;
    end else if (is_reg(index, `TB_IDX_COMPARE)) begin
      read_word[COUNT_W-1:0] = compare_capture_value;
    end else begin
      read_hit = 1'b0;
    end
    if (paddr_i[1:0] != 2'b00) begin
      read_hit = 1'b0;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      if (psel_i & penable_i & ~pready_o) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : read_word;
        pslverr_o <= ~read_hit;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_b_control_a     <= `TB_CTRL_A_RESET;
      timer_b_control_b     <= `TB_CTRL_B_RESET;
      timer_b_event_control <= `TB_TIMER_B_EVENT_CONTROL_RESET;
      counter_value         <= `TB_COUNT_ZERO;
      compare_capture_value <= `TB_COUNT_ZERO;
      capture_flag          <= 1'b0;
      overflow_flag         <= 1'b0;
      running               <= 1'b0;
      pair_state            <= ST_IDLE;
      waveform_o            <= 1'b0;
      waveform_override_o   <= 1'b0;
      capture_event_o       <= 1'b0;
      overflow_event_o      <= 1'b0;
    end else begin
      running    <= next_running;
      pair_state <= next_pair_state;
      // A software write to the count wins over the counter's own update.
      if (wr_en & is_reg(index, `TB_IDX_COUNT)) begin
        counter_value <= pwdata_i[COUNT_W-1:0];
      end else begin
        counter_value <= next_count;
      end
      if (do_capture) begin
        compare_capture_value <= counter_value;
      end else if (wr_en & is_reg(index, `TB_IDX_COMPARE)) begin
        compare_capture_value <= pwdata_i[COUNT_W-1:0];
      end
      if (wr_en & is_reg(index, `TB_IDX_CTRL_A)) begin
        timer_b_control_a <= pwdata_i[7:0] & `TB_CTRL_A_MASK;
      end
      if (wr_en & is_reg(index, `TB_IDX_CTRL_B)) begin
        timer_b_control_b <= pwdata_i[7:0] & `TB_CTRL_B_MASK;
      end
      if (wr_en & is_reg(index, `TB_IDX_TIMER_B_EVENT_CONTROL)) begin
        timer_b_event_control <= pwdata_i[7:0] & `TB_TIMER_B_EVENT_CONTROL_MASK;
      end
      // New events win over a clear that lands in the same cycle.
      if (set_capture) begin
        capture_flag <= 1'b1;
      end else if ((wr_en & is_reg(index, `TB_IDX_FLAGS) & pwdata_i[`TB_FLAG_CAPTURE]) |
                   (rd_en & is_reg(index, `TB_IDX_COMPARE) & capture_mode)) begin
        capture_flag <= 1'b0;
      end
      if (tick & running & active & (counter_value == `TB_COUNT_MAX)) begin
        overflow_flag <= 1'b1;
      end else if (wr_en & is_reg(index, `TB_IDX_FLAGS) & pwdata_i[`TB_FLAG_OVERFLOW]) begin
        overflow_flag <= 1'b0;
      end
      capture_event_o     <= set_capture;
      overflow_event_o    <= tick & running & active & (counter_value == `TB_COUNT_MAX);
      waveform_o          <= wave_level;
      // The port pin direction must be set to output elsewhere for this to reach the pad.
      waveform_override_o <= timer_b_control_b[`TB_B_OUT_EN];
    end
  end

endmodule // timer_b_control_config

// >>> timer_b_control_config_props.sv
// Port-level assertions for the type-B timer, bound to its top module.
`timescale 1ns/1ps

module timer_b_props (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire [7:0]  paddr_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [31:0] pwdata_i,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        standby_sleep_i,
  input wire        capture_event_i,
  input wire        waveform_o,
  input wire        waveform_override_o,
  input wire        capture_event_o,
  input wire        overflow_event_o
);
  reg  [7:0] ca;
  reg  [7:0] cb;
  reg  [7:0] ec;
  wire       wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  wire       snap = ca[0] && ec[0] && !ec[6] && !standby_sleep_i && cb[2:0] == 3'h2;
  wire       off = !ca[0] || (standby_sleep_i && !ca[6]);
  wire       bad = paddr_i[1:0] != 2'h0 ||
                   !(paddr_i[7:2] inside {6'h00, 6'h01, 6'h04, 6'h06, 6'h07, 6'h0A, 6'h0C});

  // Shadow copies taken only on completed writes, so refused ones never count.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ca <= 8'h00;
      cb <= 8'h00;
      ec <= 8'h00;
    end else if (wr) begin
      if (paddr_i == 8'h00)
        ca <= pwdata_i[7:0];
      if (paddr_i == 8'h04)
        cb <= pwdata_i[7:0];
      if (paddr_i == 8'h10)
        ec <= pwdata_i[7:0];
    end
  end

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_ready_wait: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
    else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_bad_addr: assert property (pready_o |-> pslverr_o == bad) else $error("error flag wrong");
  a_snap_edge: assert property (
    snap && !ca[5] && (ec[4] ? $fell(capture_event_i) : $rose(capture_event_i))
    |-> ##2 capture_event_o) else $error("capture pulse missing");
  a_wrong_edge: assert property (
    snap && !ca[5] && (ec[4] ? $rose(capture_event_i) : $fell(capture_event_i))
    |-> ##2 !capture_event_o) else $error("capture on wrong edge");
  a_cascade_lag: assert property (
    snap && ca[5] && !ec[4] && $rose(capture_event_i)
    |-> ##2 !capture_event_o ##1 capture_event_o) else $error("cascade delay wrong");
  a_gate_off: assert property (
    cb[2:0] inside {[3'h2:3'h5]} && !ec[0] && !$past(ec[0]) && !$past(ec[0], 2)
    |-> !capture_event_o) else $error("capture while input disabled");
  a_halt_quiet: assert property (
    off && $past(off) && $past(off, 2) |-> !capture_event_o && !overflow_event_o)
    else $error("event while halted");
  a_pin_override: assert property (
    wr && paddr_i == 8'h04 |-> ##2 waveform_override_o == $past(pwdata_i[4], 2))
    else $error("override wrong");
  a_async_rise: assert property (
    cb[2:0] == 3'h6 && cb[6] && ca[0] && ec[0] && !waveform_o && $rose(capture_event_i)
    |-> ##[1:2] waveform_o) else $error("async output late");
endmodule // timer_b_props

bind timer_b_control_config timer_b_props u_props (
  .clk_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pready_o,
  .pslverr_o, .standby_sleep_i, .capture_event_i, .waveform_o, .waveform_override_o,
  .capture_event_o, .overflow_event_o
);

// >>> timer_b_count_tick.v
// Count tick generator selecting the counting clock source.
`timescale 1ns/1ps
`include "timer_b_defines.vh"

module timer_b_count_tick (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire [2:0] clock_source_select_i,
  input  wire       type_a_timer_tick_i,
  input  wire       count_event_i,
  input  wire       restart_i,
  output reg        tick_o
);

  reg half_phase;
  reg count_event_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_phase    <= 1'b0;
      count_event_q <= 1'b0;
      tick_o        <= 1'b0;
    end else begin
      count_event_q <= count_event_i;
      // Restarting the halver keeps a restarted count aligned to its first tick.
      half_phase    <= restart_i ? 1'b0 : ~half_phase;
      case (clock_source_select_i)
        `TB_CLK_UNDIVIDED: tick_o <= 1'b1;
        `TB_CLK_HALVED:    tick_o <= half_phase & ~restart_i;
        `TB_CLK_TYPE_A:    tick_o <= type_a_timer_tick_i;
        `TB_CLK_EVENT:     tick_o <= count_event_i & ~count_event_q;
        default:           tick_o <= 1'b0;
      endcase
    end
  end

endmodule // timer_b_count_tick

// >>> timer_b_defines.vh
// Register map, field positions, encodings and reset values of the type-B timer.
`ifndef TIMER_B_DEFINES_VH
`define TIMER_B_DEFINES_VH

`define TB_IDX_CTRL_A      6'h00
`define TB_IDX_CTRL_B      6'h01
`define TB_IDX_TIMER_B_EVENT_CONTROL      6'h04
`define TB_IDX_FLAGS       6'h06
`define TB_IDX_STATUS      6'h07
`define TB_IDX_COUNT       6'h0A
`define TB_IDX_COMPARE     6'h0C

`define TB_CTRL_A_RESET    8'h00
`define TB_CTRL_B_RESET    8'h00
`define TB_TIMER_B_EVENT_CONTROL_RESET    8'h00
`define TB_CTRL_A_MASK     8'h7F
`define TB_CTRL_B_MASK     8'h77
`define TB_TIMER_B_EVENT_CONTROL_MASK     8'h51

`define TB_A_ENABLE        0
`define TB_A_CLOCK_SOURCE_SELECT_LO     1
`define TB_A_CLOCK_SOURCE_SELECT_HI     3
`define TB_A_RESTART_A     4
`define TB_A_CASCADE       5
`define TB_A_STANDBY       6
`define TB_B_MODE_LO       0
`define TB_B_MODE_HI       2
`define TB_B_OUT_EN        4
`define TB_B_INIT_LEVEL    5
`define TB_B_ASYNC         6
`define TB_EV_INPUT_EN     0
`define TB_EV_EDGE         4
`define TB_EV_FILTER       6
`define TB_FLAG_CAPTURE    0
`define TB_FLAG_OVERFLOW   1
`define TB_STATUS_RUN      0

`define TB_CLK_UNDIVIDED   3'h0
`define TB_CLK_HALVED      3'h1
`define TB_CLK_TYPE_A      3'h2
`define TB_CLK_EVENT       3'h7

`define TB_MODE_PERIODIC   3'h0
`define TB_MODE_TIMEOUT    3'h1
`define TB_MODE_SNAPSHOT   3'h2
`define TB_MODE_FREQ       3'h3
`define TB_MODE_WIDTH      3'h4
`define TB_MODE_FREQ_WIDTH 3'h5
`define TB_MODE_SINGLE     3'h6
`define TB_MODE_BYTE_PULSE 3'h7

`define TB_FILTER_SAMPLES  4
`define TB_COUNT_ZERO      16'h0000
`define TB_COUNT_MAX       16'hFFFF

`endif

// >>> timer_b_partner.sv
// Stand-in for the event network and the companion type-A timer.
`timescale 1ns/1ps

module timer_b_partner (
  input  wire  clk_i,
  output logic tick_o,
  output logic restart_o,
  output logic zero_restart_o,
  output logic capture_o,
  output logic count_o
);
  logic [1:0] phase = 2'h0;

  initial begin
    tick_o = 1'b0;
    restart_o = 1'b0;
    zero_restart_o = 1'b0;
    capture_o = 1'b0;
    count_o = 1'b0;
  end

  // The type-A timer runs free, so its tick lands every fourth clock.
  always @(posedge clk_i) begin
    phase <= phase + 2'h1;
    tick_o <= phase == 2'h3;
  end

  // Levels change on whole clocks only, so an event never lasts under one cycle.
  task automatic level(input logic v, input int n);
    capture_o <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic count_pulse;
    count_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    count_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic restart(input logic zero);
    if (zero)
      zero_restart_o <= 1'b1;
    else
      restart_o <= 1'b1;
    @(posedge clk_i);
    zero_restart_o <= 1'b0;
    restart_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // timer_b_partner
